// File: inc/pcr_consts.svh
// Offsets, field positions, reset values and timing constants of the PHY control registers
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH
// Register indices; byte address is four times the index
`define PCR_IDX_CONFIG_THREE 10'h01E
`define PCR_IDX_RESET_CONTROL 10'h01F
`define PCR_IDX_TEST_CHANNEL 10'h025
`define PCR_IDX_RETRY_TIMER 10'h02C
`define PCR_IDX_INT_STATUS 10'h040
`define PCR_IDX_INT_MASK 10'h041
// Config register fields
`define PCR_BIT_FD_EN 11
`define PCR_BIT_RES_XO 9
`define PCR_BIT_QUICK_XO 8
`define PCR_BIT_INT_OE 7
`define PCR_BIT_FORCE_INT 6
`define PCR_BIT_CT_FAIL 2
`define PCR_BIT_CT_DONE 1
`define PCR_BIT_CT_LAUNCH 0
`define PCR_CFG_WMASK 16'h0BC1
`define PCR_CFG_RESET 16'h0000
// Reset control fields
`define PCR_BIT_FULL_RST 15
`define PCR_BIT_RESTART 14
// Test channel and retry timer
`define PCR_BIT_LANE_ALL 7
`define PCR_LANE_LO 5
`define PCR_LANE_HI 6
`define PCR_TCH_RESET 16'h0400
`define PCR_RTM_RESET 16'h141F
// Interrupt status bits
`define PCR_NUM_EVT 3
`define PCR_EVT_CT_DONE 0
`define PCR_EVT_CT_FAIL 1
`define PCR_EVT_RST_DONE 2
// AXI responses
`define PCR_RESP_OKAY 2'h0
`define PCR_RESP_SLVERR 2'h2
// Timing
`define PCR_CLK_PERIOD_PS 8000
`define PCR_RETRY_STEP_MS 32
`define PCR_SOFT_RESET_CYCLES 16
`endif

// File: inc/pcr_pkg.sv
// Types shared by the PHY control register block
package pcr_pkg;
    typedef enum logic [0:0] {
        PCR_CT_IDLE = 1'b0,
        PCR_CT_RUN = 1'b1
    } pcr_ct_e;
    typedef enum logic [1:0] {
        PCR_XO_NORMAL = 2'b00,
        PCR_XO_RESILIENT = 2'b01,
        PCR_XO_QUICK = 2'b10
    } pcr_xo_e;
endpackage

// File: rtl/pcr_regs.sv
// PHY configuration and control register bank with AXI4-Lite access
// Function
// RULE_01: Force full duplex against forced-100 partner
// RULE_02: Bit clear: standard duplex resolution applies
// RULE_03: Bit 9 enables resilient crossover resolution
// RULE_04: Bit 8 enables quick forced-100 crossover
// RULE_05: Bit 7 makes shared pin interrupt output
// RULE_06: Bit 6 forces interrupt pin active
// RULE_07: Reserved bits ignore writes, read zero
// RULE_08: Writing bit 0 launches cable echo test
// RULE_09: Done bit reports completion, resets to one
// RULE_10: Fail bit reports failure, resets to zero
// RULE_11: Bit 15 full reset incl registers, self-clears
// RULE_12: Bit 14 restart keeps registers, self-clears
// RULE_13: Lane bit 7 drives all four channels
// RULE_14: Bits 6:5 select single channel A-D
// RULE_15: Software enables resilient crossover before timer
// RULE_16: Retry period is 32 ms steps
// RULE_17: Software read-modify-writes reserved-bearing registers
`timescale 1ns/1ps
`include "pcr_consts.svh"
module pcr_regs #(
    parameter int ADDR_W = 12,
    parameter int MS_CYCLES = 1000000000 / `PCR_CLK_PERIOD_PS,
    parameter int SOFT_RESET_CYCLES = `PCR_SOFT_RESET_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Link state from the PHY core
    input wire logic partner_forced_100,
    input wire logic local_autoneg,
    input wire logic local_forced_100,
    input wire logic ieee_full_duplex,
    output logic link_full_duplex,
    output logic [1:0] crossover_mode,
    output logic crossover_retry_pulse,
    // Cable echo test engine
    output logic cable_test_launch,
    input wire logic cable_test_finish,
    input wire logic cable_test_fault,
    // Core reset and test lanes
    output logic phy_core_reset,
    output logic [3:0] test_lane_enable,
    // Shared interrupt / power-down pin
    input wire logic irq_or_powerdown_pin_i,
    output logic irq_or_powerdown_pin_o,
    output logic irq_or_powerdown_pin_oe,
    input wire logic phy_event,
    output logic powerdown_request,
    // Bus interrupt
    output logic irq
);
    logic [15:0] cfg_reg;
    logic [15:0] tch_reg;
    logic [15:0] rtm_reg;
    logic [`PCR_NUM_EVT-1:0] int_stat_reg;
    logic [`PCR_NUM_EVT-1:0] int_mask_reg;
    logic [`PCR_NUM_EVT-1:0] evt_set;
    logic ct_done_reg;
    logic ct_fail_reg;
    pcr_pkg::pcr_ct_e ct_state_reg;
    logic full_busy_reg;
    logic restart_busy_reg;
    logic [7:0] rst_cnt_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write;
    logic [15:0] smask;
    logic wr_cfg;
    logic wr_ctl;
    logic wr_tch;
    logic wr_rtm;
    logic wr_ist;
    logic wr_imk;
    logic rst_end;

    // True when the word address selects the given register index
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
        hit = (addr[1:0] == 2'h0) && (10'(addr[ADDR_W-1:2]) == idx);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        mapped = hit(addr, `PCR_IDX_CONFIG_THREE) || hit(addr, `PCR_IDX_RESET_CONTROL)
            || hit(addr, `PCR_IDX_TEST_CHANNEL) || hit(addr, `PCR_IDX_RETRY_TIMER)
            || hit(addr, `PCR_IDX_INT_STATUS) || hit(addr, `PCR_IDX_INT_MASK);
    endfunction

    // Write path: address and data are latched in either order
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign smask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    assign wr_cfg = do_write && hit(aw_addr_reg, `PCR_IDX_CONFIG_THREE) && !full_busy_reg;
    assign wr_ctl = do_write && hit(aw_addr_reg, `PCR_IDX_RESET_CONTROL) && !full_busy_reg;
    assign wr_tch = do_write && hit(aw_addr_reg, `PCR_IDX_TEST_CHANNEL) && !full_busy_reg;
    assign wr_rtm = do_write && hit(aw_addr_reg, `PCR_IDX_RETRY_TIMER) && !full_busy_reg;
    assign wr_ist = do_write && hit(aw_addr_reg, `PCR_IDX_INT_STATUS) && !full_busy_reg;
    assign wr_imk = do_write && hit(aw_addr_reg, `PCR_IDX_INT_MASK) && !full_busy_reg;
    assign rst_end = (full_busy_reg || restart_busy_reg) && (rst_cnt_reg == 8'h00);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr_reg <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_wready <= 1'b1;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PCR_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr_reg) ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Config register: only writable bits change, reserved bits stay zero
    always_ff @(posedge mclk) begin
        if (!rst_n || full_busy_reg) begin // [RULE_11]
            cfg_reg <= `PCR_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_reg <= (cfg_reg & ~(`PCR_CFG_WMASK & smask))
                | (w_data_reg[15:0] & `PCR_CFG_WMASK & smask); // [RULE_07]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || full_busy_reg) begin
            tch_reg <= `PCR_TCH_RESET;
            rtm_reg <= `PCR_RTM_RESET;
        end else begin
            if (wr_tch) begin
                tch_reg <= (tch_reg & ~smask) | (w_data_reg[15:0] & smask);
            end
            if (wr_rtm) begin
                rtm_reg <= (rtm_reg & ~smask) | (w_data_reg[15:0] & smask);
            end
        end
    end

    // Soft reset and restart sequencing; both bits clear when the pulse ends
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            full_busy_reg <= 1'b0;
            restart_busy_reg <= 1'b0;
            rst_cnt_reg <= 8'h00;
        end else if (rst_end) begin
            full_busy_reg <= 1'b0; // [RULE_11]
            restart_busy_reg <= 1'b0; // [RULE_12]
        end else if (wr_ctl && w_strb_reg[1]) begin
            if (w_data_reg[`PCR_BIT_FULL_RST]) begin
                full_busy_reg <= 1'b1; // [RULE_11]
                rst_cnt_reg <= 8'(SOFT_RESET_CYCLES - 1);
            end else if (w_data_reg[`PCR_BIT_RESTART]) begin
                restart_busy_reg <= 1'b1; // [RULE_12]
                rst_cnt_reg <= 8'(SOFT_RESET_CYCLES - 1);
            end
        end else if (rst_cnt_reg != 8'h00) begin
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            phy_core_reset <= 1'b0;
        end else begin
            phy_core_reset <= (full_busy_reg || restart_busy_reg) && !rst_end; // [RULE_12]
        end
    end

    // Cable echo test sequencing
    always_ff @(posedge mclk) begin
        if (!rst_n || full_busy_reg) begin
            ct_state_reg <= pcr_pkg::PCR_CT_IDLE;
            ct_done_reg <= 1'b1; // [RULE_09]
            ct_fail_reg <= 1'b0; // [RULE_10]
            cable_test_launch <= 1'b0;
        end else begin
            cable_test_launch <= 1'b0;
            unique case (ct_state_reg)
                pcr_pkg::PCR_CT_IDLE: begin
                    if (wr_cfg && w_strb_reg[0] && w_data_reg[`PCR_BIT_CT_LAUNCH]) begin
                        ct_state_reg <= pcr_pkg::PCR_CT_RUN;
                        ct_done_reg <= 1'b0;
                        ct_fail_reg <= 1'b0;
                        cable_test_launch <= 1'b1; // [RULE_08]
                    end
                end
                pcr_pkg::PCR_CT_RUN: begin
                    if (cable_test_finish) begin
                        ct_state_reg <= pcr_pkg::PCR_CT_IDLE;
                        ct_done_reg <= 1'b1; // [RULE_09]
                        ct_fail_reg <= cable_test_fault; // [RULE_10]
                    end
                end
            endcase
        end
    end

    // Sticky events: a set in the same cycle as a clear wins
    assign evt_set[`PCR_EVT_CT_DONE] = (ct_state_reg == pcr_pkg::PCR_CT_RUN) && cable_test_finish;
    assign evt_set[`PCR_EVT_CT_FAIL] = (ct_state_reg == pcr_pkg::PCR_CT_RUN) && cable_test_finish
        && cable_test_fault;
    assign evt_set[`PCR_EVT_RST_DONE] = rst_end && restart_busy_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n || full_busy_reg) begin
            int_stat_reg <= '0;
            int_mask_reg <= '0;
        end else begin
            int_stat_reg <= (int_stat_reg & ~(wr_ist && w_strb_reg[0] ? w_data_reg[`PCR_NUM_EVT-1:0] : '0))
                | evt_set;
            if (wr_imk && w_strb_reg[0]) begin
                int_mask_reg <= w_data_reg[`PCR_NUM_EVT-1:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    // Read path
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `PCR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
            s_axi_rdata <= 32'h0;
            if (hit(s_axi_araddr, `PCR_IDX_CONFIG_THREE)) begin
                s_axi_rdata <= {16'h0000, cfg_reg[15:3], ct_fail_reg, ct_done_reg, cfg_reg[0]}; // [RULE_07]
            end else if (hit(s_axi_araddr, `PCR_IDX_RESET_CONTROL)) begin
                s_axi_rdata <= {16'h0000, full_busy_reg, restart_busy_reg, 14'h0000}; // [RULE_07]
            end else if (hit(s_axi_araddr, `PCR_IDX_TEST_CHANNEL)) begin
                s_axi_rdata <= {16'h0000, tch_reg};
            end else if (hit(s_axi_araddr, `PCR_IDX_RETRY_TIMER)) begin
                s_axi_rdata <= {16'h0000, rtm_reg};
            end else if (hit(s_axi_araddr, `PCR_IDX_INT_STATUS)) begin
                s_axi_rdata <= {29'h0, int_stat_reg};
            end else if (hit(s_axi_araddr, `PCR_IDX_INT_MASK)) begin
                s_axi_rdata <= {29'h0, int_mask_reg};
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Duplex and crossover resolution
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            link_full_duplex <= 1'b0;
            crossover_mode <= pcr_pkg::PCR_XO_NORMAL;
        end else begin
            if (cfg_reg[`PCR_BIT_FD_EN] && partner_forced_100 && (local_autoneg || local_forced_100)) begin
                link_full_duplex <= 1'b1; // [RULE_01]
            end else begin
                link_full_duplex <= ieee_full_duplex; // [RULE_02]
            end
            if (cfg_reg[`PCR_BIT_RES_XO]) begin
                crossover_mode <= pcr_pkg::PCR_XO_RESILIENT; // [RULE_03]
            end else if (cfg_reg[`PCR_BIT_QUICK_XO] && local_forced_100 && !local_autoneg
                && partner_forced_100) begin
                crossover_mode <= pcr_pkg::PCR_XO_QUICK; // [RULE_04]
            end else begin
                crossover_mode <= pcr_pkg::PCR_XO_NORMAL;
            end
        end
    end

    // Shared pin: active-low interrupt output or power-down input
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_or_powerdown_pin_oe <= 1'b0;
            irq_or_powerdown_pin_o <= 1'b1;
            powerdown_request <= 1'b0;
        end else begin
            irq_or_powerdown_pin_oe <= cfg_reg[`PCR_BIT_INT_OE]; // [RULE_05]
            irq_or_powerdown_pin_o <= !(cfg_reg[`PCR_BIT_FORCE_INT] || phy_event
                || (|(int_stat_reg & int_mask_reg))); // [RULE_06]
            powerdown_request <= !cfg_reg[`PCR_BIT_INT_OE] && !irq_or_powerdown_pin_i; // [RULE_05]
        end
    end

    // Lane select: bit 7 drives all lanes, else one-hot of bits 6:5
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            test_lane_enable <= 4'h0;
        end else if (tch_reg[`PCR_BIT_LANE_ALL]) begin
            test_lane_enable <= 4'hF; // [RULE_13]
        end else begin
            test_lane_enable <= 4'(4'h1 << tch_reg[`PCR_LANE_HI:`PCR_LANE_LO]); // [RULE_14]
        end
    end

    // Timer runs only while resilient crossover is enabled
    pcr_retry_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_retry (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(cfg_reg[`PCR_BIT_RES_XO]), // [RULE_15]
        .period_sel(rtm_reg[3:0]),
        .retry_tick(crossover_retry_pulse)
    );

    sequence s_cfg_launch;
        wr_cfg && w_strb_reg[0] && w_data_reg[`PCR_BIT_CT_LAUNCH] && ct_state_reg == pcr_pkg::PCR_CT_IDLE;
    endsequence
    sequence s_cfg_read;
        s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, `PCR_IDX_CONFIG_THREE);
    endsequence

    AST_FD_FORCED: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_01]
        cfg_reg[`PCR_BIT_FD_EN] && partner_forced_100 && local_autoneg |=> link_full_duplex)
        else $error("full duplex not forced");
    AST_FD_IEEE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_02]
        !cfg_reg[`PCR_BIT_FD_EN] |=> link_full_duplex == $past(ieee_full_duplex))
        else $error("duplex does not follow standard resolution");
    AST_XO_RESILIENT: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_03]
        cfg_reg[`PCR_BIT_RES_XO] |=> crossover_mode == pcr_pkg::PCR_XO_RESILIENT)
        else $error("resilient crossover not selected");
    AST_XO_QUICK: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_04]
        !cfg_reg[`PCR_BIT_RES_XO] && !cfg_reg[`PCR_BIT_QUICK_XO] |=> crossover_mode == pcr_pkg::PCR_XO_NORMAL)
        else $error("quick crossover without enable");
    AST_PIN_ROLE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_05]
        cfg_reg[`PCR_BIT_INT_OE] ##1 cfg_reg[`PCR_BIT_INT_OE] |-> irq_or_powerdown_pin_oe && !powerdown_request)
        else $error("pin role does not follow enable");
    AST_FORCE_INT: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_06]
        cfg_reg[`PCR_BIT_FORCE_INT] |=> !irq_or_powerdown_pin_o)
        else $error("forced interrupt not driven");
    AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_07]
        s_cfg_read |=> s_axi_rdata[5:3] == 3'h0) else $error("reserved config bits read nonzero");
    AST_CT_LAUNCH: assert property (@(posedge mclk) disable iff (!rst_n || full_busy_reg) // [RULE_08]
        s_cfg_launch |=> cable_test_launch && !ct_done_reg ##1 !cable_test_launch)
        else $error("cable test launch pulse wrong");
    AST_CT_DONE: assert property (@(posedge mclk) disable iff (!rst_n || full_busy_reg) // [RULE_09]
        ct_state_reg == pcr_pkg::PCR_CT_RUN && cable_test_finish |=> ct_done_reg
        && ct_fail_reg == $past(cable_test_fault)) else $error("cable test result not captured");
    AST_FULL_RESET: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_11]
        full_busy_reg |=> cfg_reg == `PCR_CFG_RESET && tch_reg == `PCR_TCH_RESET)
        else $error("registers not at defaults during full reset");
    AST_SELF_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_12]
        rst_end |=> !full_busy_reg && !restart_busy_reg) else $error("reset bit did not self-clear");
    AST_LANE_ALL: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_13]
        tch_reg[`PCR_BIT_LANE_ALL] |=> test_lane_enable == 4'hF) else $error("not all lanes driven");
    AST_LANE_ONE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_14]
        !tch_reg[`PCR_BIT_LANE_ALL] |=> $onehot(test_lane_enable)) else $error("single lane not one-hot");
endmodule

// File: rtl/pcr_retry_timer.sv
// Resilient crossover retry timer: one pulse per programmed period
`timescale 1ns/1ps
`include "pcr_consts.svh"
module pcr_retry_timer #(
    parameter int MS_CYCLES = 1000000000 / `PCR_CLK_PERIOD_PS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic [3:0] period_sel,
    // Result
    output logic retry_tick
);
    logic [31:0] ms_cnt_reg;
    logic ms_tick;
    logic [8:0] step_cnt_reg;
    logic [8:0] step_limit;

    assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));
    // Period is (code + 1) steps of 32 ms
    assign step_limit = 9'(({5'h00, period_sel} + 9'h001) * `PCR_RETRY_STEP_MS - 1); // [RULE_16]

    always_ff @(posedge mclk) begin
        if (!rst_n || !enable) begin
            ms_cnt_reg <= 32'h0;
        end else if (ms_tick) begin
            ms_cnt_reg <= 32'h0;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || !enable) begin
            step_cnt_reg <= 9'h000;
            retry_tick <= 1'b0;
        end else begin
            retry_tick <= 1'b0;
            if (ms_tick) begin
                if (step_cnt_reg >= step_limit) begin
                    step_cnt_reg <= 9'h000;
                    retry_tick <= 1'b1; // [RULE_16]
                end else begin
                    step_cnt_reg <= step_cnt_reg + 9'h001;
                end
            end
        end
    end

    AST_RETRY_ONLY_ENABLED: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_16]
        !enable |=> !retry_tick) else $error("retry tick while timer disabled");
endmodule

// File: tb/tb_top.sv
// Self-checking testbench for the PHY control register bank
`timescale 1ns/1ps
`include "pcr_consts.svh"
module tb_top;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic pf = 1'h0, an = 1'h0, lf = 1'h0, ieee = 1'h0, fin = 1'h0, flt = 1'h0, pin_i = 1'h1, evt = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, fd, rtp, launch, core_rst, pin_o, oe, pdr, irq;
    logic [1:0] bresp, rresp, xo;
    logic [31:0] rdata;
    logic [3:0] lanes;
    logic [31:0] rnd = 32'h0000AD5A;
    logic [31:0] r;
    logic [9:0] e;
    logic [31:0] v;
    logic [15:0] c;
    logic [1:0] rsp;
    int err_count = 0, compares = 0, cyc = 0, nl = 0, t0, t1;
    logic [9:0] idx [4] = '{`PCR_IDX_CONFIG_THREE, `PCR_IDX_RESET_CONTROL, `PCR_IDX_TEST_CHANNEL,
        `PCR_IDX_RETRY_TIMER};
    logic [15:0] dflt [4] = '{16'h0002, 16'h0000, `PCR_TCH_RESET, `PCR_RTM_RESET};
    pcr_regs #(.MS_CYCLES(10)) u_dut (.mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .partner_forced_100(pf), .local_autoneg(an), .local_forced_100(lf),
        .ieee_full_duplex(ieee), .link_full_duplex(fd), .crossover_mode(xo), .crossover_retry_pulse(rtp),
        .cable_test_launch(launch), .cable_test_finish(fin), .cable_test_fault(flt), .phy_core_reset(core_rst),
        .test_lane_enable(lanes), .irq_or_powerdown_pin_i(pin_i), .irq_or_powerdown_pin_o(pin_o),
        .irq_or_powerdown_pin_oe(oe), .phy_event(evt), .powerdown_request(pdr), .irq(irq));
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (launch === 1'h1) nl <= nl + 1;
    end
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Expected {duplex, crossover, oe, pin level, power-down, lanes}
    function logic [9:0] exp_out(input logic [15:0] c, input logic [7:0] t);
        logic [1:0] x;
        x = c[9] ? 2'h1 : (c[8] && lf && !an && pf) ? 2'h2 : 2'h0;
        return {(c[11] && pf && (an || lf)) || ieee, x, c[7], !(c[6] || evt), !c[7] && !pin_i,
            t[7] ? 4'hF : (4'h1 << t[6:5])};
    endfunction
    task stop_test;
        $display("errors=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task tmo(input bit f);
        if (f) begin
            chk(32'h1, 32'h0);
            stop_test;
        end
    endtask
    task wr(input logic [9:0] i, input logic [15:0] d);
        int n;
        @(posedge mclk);
        awaddr <= {i, 2'h0};
        wdata <= {16'h0000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 200; n++) begin
            @(posedge mclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
            if (bvalid === 1'h1) break;
        end
        rsp = bresp;
        bready <= 1'h0;
        tmo(n >= 200);
    endtask
    task rd(input logic [9:0] i);
        int n;
        @(posedge mclk);
        araddr <= {i, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 200; n++) begin
            @(posedge mclk);
            if (arready === 1'h1) arvalid <= 1'h0;
            if (rvalid === 1'h1) break;
        end
        v = rdata;
        rsp = rresp;
        rready <= 1'h0;
        tmo(n >= 200);
    endtask
    task wait_low(input bit pulse);
        int n;
        for (n = 0; n < 3000; n++) begin
            @(posedge mclk);
            if (pulse ? rtp === 1'h1 : core_rst === 1'h0) break;
        end
        tmo(n >= 3000);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            rd(idx[k]);
            chk(v, {16'h0000, dflt[k]});
        end
        chk({oe, pin_o, pdr}, 3'h2);
        rd(10'h3FF);
        chk({rsp, v[15:0]}, {`PCR_RESP_SLVERR, 16'h0000});
        wr(10'h3FF, 16'hFFFF);
        chk(rsp, `PCR_RESP_SLVERR);
        wr(`PCR_IDX_RESET_CONTROL, 16'h3FFF);
        rd(`PCR_IDX_RESET_CONTROL);
        chk(v, 32'h0);
        wr(`PCR_IDX_CONFIG_THREE, 16'hFFFF);
        rd(`PCR_IDX_CONFIG_THREE);
        chk(v, 32'h0BC1);
        chk({nl[3:0], oe, pin_o}, 6'h6);
        @(posedge mclk);
        fin <= 1'h1;
        flt <= 1'h1;
        @(posedge mclk);
        fin <= 1'h0;
        flt <= 1'h0;
        rd(`PCR_IDX_CONFIG_THREE);
        chk(v, 32'h0BC7);
        rd(`PCR_IDX_INT_STATUS);
        chk({v[15:0], irq}, 17'h00006);
        wr(`PCR_IDX_INT_MASK, 16'h0003);
        rd(`PCR_IDX_INT_MASK);
        chk({v[15:0], irq}, 17'h00007);
        wr(`PCR_IDX_INT_STATUS, 16'h0003);
        rd(`PCR_IDX_INT_STATUS);
        chk({v[15:0], irq}, 17'h00000);
        wr(`PCR_IDX_CONFIG_THREE, 16'h0A80);
        wr(`PCR_IDX_RESET_CONTROL, 16'h4000);
        rd(`PCR_IDX_RESET_CONTROL);
        chk({v[15:0], core_rst}, 17'h08001);
        wait_low(1'h0);
        rd(`PCR_IDX_CONFIG_THREE);
        chk(v, 32'h0A86);
        rd(`PCR_IDX_RESET_CONTROL);
        chk(v, 32'h0);
        rd(`PCR_IDX_INT_STATUS);
        chk(v, 32'h4);
        wr(`PCR_IDX_TEST_CHANNEL, 16'h0420);
        wr(`PCR_IDX_RESET_CONTROL, 16'h8000);
        wait_low(1'h0);
        for (int k = 0; k < 4; k++) begin
            rd(idx[k]);
            chk(v, {16'h0000, dflt[k]});
        end
        for (int k = 0; k < 60; k++) begin
            rnd = xs(rnd);
            r = (k == 0) ? 32'hA0800900 : rnd;
            c = r[15:0] & 16'h0BC0;
            wr(`PCR_IDX_CONFIG_THREE, c);
            wr(`PCR_IDX_TEST_CHANNEL, {8'h04, r[23:16]});
            {pf, an, lf, ieee, evt, pin_i} <= r[31:26];
            repeat (3) @(posedge mclk);
            e = exp_out(c, r[23:16]);
            chk({fd, xo}, e[9:7]);
            chk({oe, pin_o, pdr, lanes}, e[6:0]);
        end
        wr(`PCR_IDX_CONFIG_THREE, 16'h0200);
        for (int j = 0; j < 3; j += 2) begin
            wr(`PCR_IDX_RETRY_TIMER, 16'h1410 | j[15:0]);
            wait_low(1'h1);
            t0 = cyc;
            wait_low(1'h1);
            t1 = cyc;
            chk(t1 - t0, (j + 1) * 32 * 10);
        end
        stop_test;
    end
endmodule
